// ==== sra_pkg.sv ====
// Purpose: Shared constants and types of the serial register access port
// Assumes: 10 MHz core clock
// Notes: Offsets are byte addresses inside every register page
package sra_pkg;
  // Reserved addresses present on every page
  localparam logic [7:0] ADDR_WIN_LO = 8'hf0;
  localparam logic [7:0] ADDR_WIN_HI = 8'hf7;
  localparam logic [7:0] ADDR_STATUS = 8'hfe;
  localparam logic [7:0] ADDR_PAGE = 8'hff;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  // Command byte layout
  localparam logic [2:0] CMD_NORMAL_TAG = 3'h3;
  localparam int CMD_MODE_BIT = 4;
  // Status byte layout
  localparam int ST_READ_ACK_FLAG_BIT = 5;
  localparam int ST_RECEIVE_READY_FLAG_BIT = 1;
  localparam int ST_TRANSMIT_READY_FLAG_BIT = 0;
  // Loader header and serial memory framing
  localparam logic [4:0] HDR_MAGIC = 5'h15;
  localparam int HDR_SPEED_BIT = 10;
  localparam logic [2:0] EE_READ_OP = 3'h6;
  localparam int EE_ADDR_MAX = 10;
  localparam logic [4:0] EE_FRAME_EXTRA = 5'h14;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // Serial memory clock half periods
  localparam int CLK_PERIOD_NS = 100;
  localparam int EE_HALF_NORM_NS = 500;
  localparam int EE_HALF_FAST_NS = 250;
  localparam logic [3:0] EE_HALF_NORM_CYC =
    4'((EE_HALF_NORM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] EE_HALF_FAST_CYC =
    4'((EE_HALF_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {SP_CMD, SP_ADDR, SP_DATA, SP_SKIP} spi_state_t;
  typedef enum logic [2:0] {
    LD_WAIT, LD_SHIFT, LD_WORD, LD_EXEC, LD_DONE, LD_ABSENT
  } ld_state_t;

  // Address bits sent per read for each size strap
  function automatic logic [3:0] ee_addr_bits(input logic [1:0] sz);
    unique case (sz)
      2'h0: ee_addr_bits = 4'h6;
      2'h1: ee_addr_bits = 4'h7;
      2'h2: ee_addr_bits = 4'h8;
      default: ee_addr_bits = 4'ha;
    endcase
  endfunction

  // Words held by the part for each size strap
  function automatic logic [10:0] ee_words(input logic [1:0] sz);
    unique case (sz)
      2'h0: ee_words = 11'h040;
      2'h1: ee_words = 11'h080;
      2'h2: ee_words = 11'h100;
      default: ee_words = 11'h400;
    endcase
  endfunction
endpackage

// ==== reg_if.sv ====
// Purpose: Request and answer path into the register space
// Assumes: Requests held until ack
// Notes: One instance per requester
`timescale 1ns/10ps
interface reg_if;
  logic req;
  logic write;
  logic [7:0] page;
  logic [7:0] addr;
  logic [63:0] wdata;
  logic ack;
  logic [63:0] rdata;
  logic [3:0] width;
  modport initiator (output req, write, page, addr, wdata,
                     input ack, rdata, width);
  modport target (input req, write, page, addr, wdata,
                  output ack, rdata, width);
endinterface

// ==== reg_arbiter.sv ====
// Purpose: Routes serial slave or loader onto the one register space
// Assumes: Requesters hold req until ack
// Notes: Owner changes only between requests
`timescale 1ns/10ps
module reg_arbiter
  import sra_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Strap selected source
  input wire logic ee_mode,
  // Requesters
  reg_if.target spi,
  reg_if.target ldr,
  // Register space
  output logic reg_req,
  output logic reg_write,
  output logic [7:0] reg_page,
  output logic [7:0] reg_addr,
  output logic [63:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic [63:0] reg_rdata,
  input wire logic [3:0] reg_width
);
  typedef struct packed {
    logic owner;
    logic lock;
  } arb_t;
  arb_t st_ff;
  arb_t nxt_st;

  // Owner follows the strap unless a request is in flight
  always_comb begin
    nxt_st = st_ff;
    nxt_st.lock = reg_req & ~reg_ack;
    if (!st_ff.lock) begin
      nxt_st.owner = ee_mode;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Both sources reach the same register space
  assign reg_req = st_ff.owner ? ldr.req : spi.req; // RQ24
  assign reg_write = st_ff.owner ? ldr.write : spi.write;
  assign reg_page = st_ff.owner ? ldr.page : spi.page;
  assign reg_addr = st_ff.owner ? ldr.addr : spi.addr;
  assign reg_wdata = st_ff.owner ? ldr.wdata : spi.wdata;
  assign spi.ack = ~st_ff.owner & reg_ack;
  assign ldr.ack = st_ff.owner & reg_ack;
  assign spi.rdata = reg_rdata;
  assign ldr.rdata = reg_rdata;
  assign spi.width = reg_width;
  assign ldr.width = reg_width;
endmodule // reg_arbiter

// ==== serial_register_access_port.sv ====
// Purpose: Serial slave and boot loader front end of the register space
// Assumes: clk 10 MHz; link clock sampled, never used as a clock
// Notes: Shared pins are split into input, output and enable
// Behaviour
// [RQ1] Command byte: bit4 mode, bits3:1 select id, bit0 direction
// [RQ2] Master keeps select low for a transaction, raises it to end
// [RQ3] Offset FEh of every page shows the serial status byte
// [RQ4] Normal read is command byte plus one address byte
// [RQ5] Write happens only when data byte count equals register width
// [RQ6] Master writes FFh only when moving to another page
// [RQ7] Read-ack flag sets once the read data has been fetched
// [RQ8] Read data window sits at F0h to F7h on every page
// [RQ9] First window read gives byte n, repeats give next higher bytes
// [RQ10] A new transaction is taken with fetched bytes still unread
// [RQ11] Write data arrives low byte first, no byte offset
// [RQ12] Any page write returns the serial state to its start; a read answer in the same cycle still sets the read-ack flag
// [RQ13] Master checks ready flags after each 8-byte string
// [RQ14] Fast read streams ack bytes on bit 0, then data low first
// [RQ15] Fast command bits 7:5 give the first byte returned
// [RQ16] Writes behave the same in fast and normal mode
// [RQ17] Header without magic 15h stops loader as if no part
// [RQ18] Header: magic 15:11, speed bit 10, entry count 9:0
// [RQ19] Entries fetched in turn and written at once
// [RQ20] Size strap picks the read framing for 64 to 1024 words
// [RQ21] Entry count limited to the part size
// [RQ22] Stored words are byte swapped
// [RQ23] Serial memory is organised as 16-bit words
// [RQ24] Strap picks slave or loader; both reach one register space
// [RQ25] Link idles low, samples on rising edge, MSB first
`timescale 1ns/10ps
module serial_register_access_port
  import sra_pkg::*;
#(
  parameter logic [2:0] DEV_SELECT_ID = 3'h0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Straps and chip status
  input wire logic loader_strap,
  input wire logic [1:0] rom_size_select,
  input wire logic init_done,
  input wire logic receive_ready_flag,
  input wire logic transmit_ready_flag,
  // Shared serial pins
  input wire logic ser_clk_i,
  output logic ser_clk_o,
  output logic ser_clk_oe,
  input wire logic ser_sel_i,
  output logic ser_sel_o,
  output logic ser_sel_oe,
  input wire logic ser_mosi_i,
  output logic ser_mosi_o,
  output logic ser_mosi_oe,
  input wire logic ser_miso_i,
  output logic ser_miso_o,
  output logic ser_miso_oe,
  // Register space
  output logic reg_req,
  output logic reg_write,
  output logic [7:0] reg_page,
  output logic [7:0] reg_addr,
  output logic [63:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic [63:0] reg_rdata,
  input wire logic [3:0] reg_width,
  // Loader status
  output logic loader_present,
  output logic loader_done,
  output logic loader_fast
);
  typedef struct packed {
    logic [1:0] sck_s;
    logic [1:0] ss_s;
    logic [1:0] mosi_s;
    logic [1:0] miso_s;
    logic [1:0] mode_s;
    logic [3:0] size_s;
    logic sck_d;
    logic ss_d;
    logic [1:0] stc;
    logic ee_mode;
    logic [1:0] rom_size;
    spi_state_t sst;
    logic [2:0] bitc;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [7:0] cmd;
    logic [7:0] addr;
    logic [7:0] page;
    logic [63:0] wbuf;
    logic [3:0] wcnt;
    logic [63:0] rbuf;
    logic [3:0] rwidth;
    logic read_ack_flag;
    logic [2:0] ptr;
    logic [2:0] ptr_win;
    logic ptr_valid;
    logic fack;
    logic [2:0] fptr;
    logic sreq;
    logic swr;
    ld_state_t lst;
    logic [3:0] div;
    logic sk;
    logic cs;
    logic [4:0] bitn;
    logic [12:0] osh;
    logic [15:0] ish;
    logic [9:0] widx;
    logic [9:0] wlim;
    logic fast;
    logic [15:0] ent;
    logic lreq;
    logic present;
    logic done;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic sck_rise;
  logic sck_fall;
  logic ss_on;
  logic ss_end;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [7:0] status;
  logic [15:0] ee_word;
  logic do_next_fast_ack;
  reg_if spi_bus ();
  reg_if ldr_bus ();

  // Byte idx of a 64-bit buffer
  function automatic logic [7:0] byte_of(input logic [63:0] buf_v,
                                         input logic [2:0] idx);
    byte_of = buf_v[{idx, 3'h0} +: 8];
  endfunction

  // Steps a byte pointer up to the register's top byte
  function automatic logic [2:0] step_ptr(input logic [2:0] p,
                                          input logic [3:0] w);
    step_ptr = ({1'b0, p} + 4'h1 < w) ? p + 3'h1 : p;
  endfunction

  // Edges of the sampled link clock and frame
  assign sck_rise = st_ff.sck_s[1] & ~st_ff.sck_d; // RQ25
  assign sck_fall = ~st_ff.sck_s[1] & st_ff.sck_d;
  assign ss_on = ~st_ff.ss_s[1] & ~st_ff.ee_mode & (st_ff.stc == STRAP_SETTLE);
  assign ss_end = st_ff.ss_s[1] & ~st_ff.ss_d; // RQ2
  assign byte_done = ss_on & sck_rise & (st_ff.bitc == 3'h7);
  assign rx_byte = {st_ff.rx[6:0], st_ff.mosi_s[1]}; // RQ25
  assign ee_word = {st_ff.ish[7:0], st_ff.ish[15:8]}; // RQ22

  // Status byte seen at FEh
  always_comb begin
    status = '0;
    status[ST_READ_ACK_FLAG_BIT] = st_ff.read_ack_flag; // RQ3
    status[ST_RECEIVE_READY_FLAG_BIT] = receive_ready_flag;
    status[ST_TRANSMIT_READY_FLAG_BIT] = transmit_ready_flag;
  end

  // Next state of slave, loader and synchronisers
  always_comb begin
    logic [7:0] ra;
    logic [2:0] p;
    logic do_next;
    logic launch;
    logic go;
    logic [3:0] ab;
    logic [3:0] half;
    logic [9:0] cnt;
    logic [10:0] words;
    nxt_st = st_ff;
    ra = (st_ff.sst == SP_ADDR) ? rx_byte : st_ff.addr;
    p = '0;
    launch = 1'b0;
    go = 1'b0;
    ab = ee_addr_bits(st_ff.rom_size); // RQ20
    half = st_ff.fast ? EE_HALF_FAST_CYC : EE_HALF_NORM_CYC;
    cnt = ee_word[9:0]; // RQ18
    words = ee_words(st_ff.rom_size);
    do_next = byte_done & ~st_ff.cmd[0] & ((st_ff.sst == SP_DATA) |
      ((st_ff.sst == SP_ADDR) & (rx_byte >= ADDR_WIN_LO)));
    nxt_st.sck_s = {st_ff.sck_s[0], ser_clk_i};
    nxt_st.ss_s = {st_ff.ss_s[0], ser_sel_i};
    nxt_st.mosi_s = {st_ff.mosi_s[0], ser_mosi_i};
    nxt_st.miso_s = {st_ff.miso_s[0], ser_miso_i};
    nxt_st.mode_s = {st_ff.mode_s[0], loader_strap};
    nxt_st.size_s = {st_ff.size_s[1:0], rom_size_select};
    nxt_st.sck_d = st_ff.sck_s[1];
    nxt_st.ss_d = st_ff.ss_s[1];
    // Straps caught once the synchronisers have filled
    if (st_ff.stc != STRAP_SETTLE) begin
      nxt_st.stc = st_ff.stc + 2'h1;
      nxt_st.ee_mode = st_ff.mode_s[1]; // RQ24
      nxt_st.rom_size = st_ff.size_s[3:2];
    end
    // Serial slave framing
    if (!ss_on) begin
      nxt_st.sst = SP_CMD; // RQ10
      nxt_st.bitc = '0;
    end else begin
      if (sck_fall && st_ff.bitc != 3'h0) begin
        nxt_st.tx = {st_ff.tx[6:0], 1'b0}; // RQ25
      end
      if (sck_rise) begin
        nxt_st.rx = rx_byte;
        nxt_st.bitc = st_ff.bitc + 3'h1;
      end
      if (byte_done) begin
        unique case (st_ff.sst)
          SP_CMD: begin
            nxt_st.cmd = rx_byte;
            nxt_st.sst = (rx_byte[3:1] == DEV_SELECT_ID &&
              (rx_byte[CMD_MODE_BIT] || rx_byte[7:5] == CMD_NORMAL_TAG))
              ? SP_ADDR : SP_SKIP; // RQ1
          end
          SP_ADDR: begin
            nxt_st.addr = rx_byte;
            nxt_st.wcnt = '0;
            nxt_st.wbuf = '0; // No stale upper bytes in narrow writes
            nxt_st.sst = SP_DATA;
            if (!st_ff.cmd[0] && rx_byte < ADDR_WIN_LO) begin
              launch = 1'b1; // RQ4
              nxt_st.sreq = 1'b1;
              nxt_st.swr = 1'b0;
              nxt_st.read_ack_flag = 1'b0;
              nxt_st.ptr_valid = 1'b0;
              nxt_st.fack = 1'b0;
              nxt_st.fptr = st_ff.cmd[7:5]; // RQ15
              nxt_st.tx = '0;
            end
          end
          SP_DATA: begin
            if (st_ff.cmd[0]) begin
              if (!st_ff.wcnt[3]) begin
                nxt_st.wbuf[{st_ff.wcnt[2:0], 3'h0} +: 8] = rx_byte; // RQ11
              end
              if (st_ff.wcnt != 4'h9) begin
                nxt_st.wcnt = st_ff.wcnt + 4'h1;
              end
            end
          end
          SP_SKIP: begin
          end
        endcase
      end
    end
    // Next byte to shift out on a read
    if (do_next) begin
      if (ra < ADDR_WIN_LO) begin
        if (!st_ff.cmd[CMD_MODE_BIT]) begin
          nxt_st.tx = '0;
        end else if (!st_ff.fack) begin
          nxt_st.tx = {7'h0, st_ff.read_ack_flag}; // RQ14
          nxt_st.fack = st_ff.read_ack_flag;
        end else begin
          nxt_st.tx = byte_of(st_ff.rbuf, st_ff.fptr); // RQ14
          nxt_st.fptr = step_ptr(st_ff.fptr, st_ff.rwidth);
        end
      end else if (ra <= ADDR_WIN_HI) begin
        p = (st_ff.ptr_valid && st_ff.ptr_win == ra[2:0]) ?
          st_ff.ptr : ra[2:0]; // RQ9
        nxt_st.tx = byte_of(st_ff.rbuf, p); // RQ8
        nxt_st.ptr = step_ptr(p, st_ff.rwidth);
        nxt_st.ptr_win = ra[2:0];
        nxt_st.ptr_valid = 1'b1;
      end else if (ra == ADDR_STATUS) begin
        nxt_st.tx = status; // RQ3
      end else if (ra == ADDR_PAGE) begin
        nxt_st.tx = st_ff.page;
      end else begin
        nxt_st.tx = '0;
      end
    end
    // Write takes effect at the end of the frame, both modes alike
    if (ss_end && st_ff.sst == SP_DATA && st_ff.cmd[0]) begin // RQ16
      if (st_ff.addr == ADDR_PAGE) begin
        if (st_ff.wcnt == 4'h1) begin
          nxt_st.page = st_ff.wbuf[7:0]; // RQ12
          nxt_st.read_ack_flag = 1'b0;
          nxt_st.ptr_valid = 1'b0;
          nxt_st.fack = 1'b0;
          nxt_st.sreq = 1'b0;
        end
      end else if (st_ff.addr < ADDR_WIN_LO && !st_ff.sreq &&
                   st_ff.wcnt == spi_bus.width) begin // RQ5
        nxt_st.sreq = 1'b1;
        nxt_st.swr = 1'b1;
      end
    end
    // Answer from the register space; a set beats a clear
    if (st_ff.sreq && spi_bus.ack) begin
      nxt_st.sreq = launch;
      if (!st_ff.swr && !launch) begin
        nxt_st.rbuf = spi_bus.rdata;
        nxt_st.rwidth = spi_bus.width;
        nxt_st.read_ack_flag = 1'b1; // RQ7
      end
    end
    // Loader sequence
    unique case (st_ff.lst)
      LD_WAIT: begin
        if (st_ff.stc == STRAP_SETTLE && st_ff.ee_mode && init_done) begin
          nxt_st.widx = '0; // RQ24
          go = 1'b1;
        end
      end
      LD_SHIFT: begin
        if (st_ff.div != 4'h0) begin
          nxt_st.div = st_ff.div - 4'h1;
        end else begin
          nxt_st.div = half - 4'h1;
          if (!st_ff.sk) begin
            nxt_st.sk = 1'b1;
            nxt_st.ish = {st_ff.ish[14:0], st_ff.miso_s[1]};
          end else begin
            nxt_st.sk = 1'b0;
            nxt_st.osh = {st_ff.osh[11:0], 1'b0};
            nxt_st.bitn = st_ff.bitn + 5'h1;
            if (st_ff.bitn == 5'(ab) + EE_FRAME_EXTRA - 5'h1) begin
              nxt_st.cs = 1'b0; // RQ20
              nxt_st.lst = LD_WORD;
            end
          end
        end
      end
      LD_WORD: begin
        if (st_ff.widx == 10'h0) begin
          if (ee_word[15:11] != HDR_MAGIC) begin
            nxt_st.lst = LD_ABSENT; // RQ17
          end else begin
            nxt_st.present = 1'b1;
            nxt_st.fast = ee_word[HDR_SPEED_BIT]; // RQ18
            nxt_st.wlim = ({1'b0, cnt} >= words) ?
              10'(words - 11'h1) : cnt; // RQ21
          end
        end else if (st_ff.widx[0]) begin
          nxt_st.ent = ee_word;
        end else begin
          nxt_st.lreq = 1'b1; // RQ19
          nxt_st.lst = LD_EXEC;
        end
      end
      LD_EXEC: begin
        if (ldr_bus.ack) begin
          nxt_st.lreq = 1'b0;
        end
      end
      LD_DONE: begin
        nxt_st.done = 1'b1;
      end
      LD_ABSENT: begin
      end
    endcase
    // Move to the next word or finish
    if ((st_ff.lst == LD_WORD && nxt_st.lst == LD_WORD) ||
        (st_ff.lst == LD_EXEC && ldr_bus.ack)) begin
      if (st_ff.widx == nxt_st.wlim) begin
        nxt_st.lst = LD_DONE; // RQ19
      end else begin
        nxt_st.widx = st_ff.widx + 10'h1;
        go = 1'b1;
      end
    end
    if (go) begin
      nxt_st.lst = LD_SHIFT;
      nxt_st.cs = 1'b1;
      nxt_st.sk = 1'b0;
      nxt_st.bitn = '0;
      nxt_st.div = half - 4'h1;
      nxt_st.osh = {EE_READ_OP,
        10'(nxt_st.widx << (4'(EE_ADDR_MAX) - ab))}; // RQ20
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
      st_ff.page <= PAGE_RESET;
      st_ff.ss_s <= '1; // Idle select level, no false frame end
      st_ff.ss_d <= 1'b1;
      st_ff.sst <= SP_CMD;
      st_ff.lst <= LD_WAIT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Requests into the register space
  assign spi_bus.req = st_ff.sreq;
  assign spi_bus.write = st_ff.swr;
  assign spi_bus.page = st_ff.page;
  assign spi_bus.addr = st_ff.addr;
  assign spi_bus.wdata = st_ff.wbuf;
  assign ldr_bus.req = st_ff.lreq;
  assign ldr_bus.write = 1'b1;
  assign ldr_bus.page = st_ff.ent[15:8];
  assign ldr_bus.addr = st_ff.ent[7:0];
  assign ldr_bus.wdata = {48'h0, ee_word};

  reg_arbiter u_arb (
    .clk(clk),
    .resetn(resetn),
    .ee_mode(st_ff.ee_mode),
    .spi(spi_bus),
    .ldr(ldr_bus),
    .reg_req(reg_req),
    .reg_write(reg_write),
    .reg_page(reg_page),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_ack(reg_ack),
    .reg_rdata(reg_rdata),
    .reg_width(reg_width)
  );

  // Shared pins: loader drives clock, select and data in loader mode
  assign ser_clk_o = st_ff.sk;
  assign ser_sel_o = st_ff.cs;
  assign ser_mosi_o = st_ff.osh[12] & st_ff.cs;
  assign ser_clk_oe = st_ff.ee_mode & (st_ff.stc == STRAP_SETTLE);
  assign ser_sel_oe = ser_clk_oe;
  assign ser_mosi_oe = ser_clk_oe;
  assign ser_miso_o = st_ff.tx[7];
  assign ser_miso_oe = ss_on; // RQ24
  assign loader_present = st_ff.present;
  assign loader_done = st_ff.done;
  assign loader_fast = st_ff.fast;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  AST_CMD_FILTER: assert property ( // RQ1
    byte_done && st_ff.sst == SP_CMD && rx_byte[3:1] != DEV_SELECT_ID
    |=> st_ff.sst != SP_ADDR)
    else $error("foreign select id accepted");
  AST_READ_LAUNCH: assert property ( // RQ4
    byte_done && st_ff.sst == SP_ADDR && !st_ff.cmd[0] &&
    rx_byte < ADDR_WIN_LO |=> st_ff.sreq && !st_ff.swr && !st_ff.read_ack_flag)
    else $error("read not launched after address byte");
  AST_READ_ACK_FLAG_ON_ACK: assert property ( // RQ7
    st_ff.sreq && !st_ff.swr && spi_bus.ack && !byte_done
    |=> st_ff.read_ack_flag && !st_ff.sreq)
    else $error("read ack flag not set");
  AST_WRITE_COUNT: assert property ( // RQ5
    st_ff.sreq && st_ff.swr && !$past(st_ff.sreq)
    |-> $past(st_ff.wcnt) == $past(spi_bus.width))
    else $error("write issued with wrong byte count");
  AST_PAGE_RESET: assert property ( // RQ12
    ss_end && st_ff.sst == SP_DATA && st_ff.cmd[0] &&
    st_ff.addr == ADDR_PAGE && st_ff.wcnt == 4'h1 && !spi_bus.ack
    |=> !st_ff.ptr_valid && !st_ff.read_ack_flag && !st_ff.sreq)
    else $error("page write did not reset slave");
  AST_MAGIC_STOP: assert property ( // RQ17
    st_ff.lst == LD_WORD && st_ff.widx == 10'h0 &&
    ee_word[15:11] != HDR_MAGIC |=> st_ff.lst == LD_ABSENT [*3])
    else $error("loader ran without magic");
  AST_WLIM: assert property ( // RQ21
    st_ff.lst != LD_WAIT |-> {1'b0, st_ff.wlim} < ee_words(st_ff.rom_size))
    else $error("entry limit beyond part size");
  AST_SHARE: assert property ( // RQ24
    st_ff.ee_mode && $past(st_ff.ee_mode)
    |-> !ser_miso_oe && reg_req == st_ff.lreq)
    else $error("slave active in loader mode");
  AST_EXEC_HOLD: assert property ( // RQ19
    st_ff.lst == LD_EXEC |-> reg_req && reg_write)
    else $error("loader entry not presented");

  COV_FAST_ACK: cover property (
    do_next_fast_ack);
  COV_PAGE_WRITE: cover property (
    ss_end && st_ff.addr == ADDR_PAGE && st_ff.cmd[0]);
  COV_LOAD_DONE: cover property (
    st_ff.lst == LD_EXEC ##[1:50] st_ff.lst == LD_DONE);

  assign do_next_fast_ack = st_ff.fack && st_ff.cmd[CMD_MODE_BIT];
endmodule // serial_register_access_port

// ==== ee_model.sv ====
// Purpose: Serial memory model answering the boot loader
// Assumes: 16-bit words, AB address bits per read
// Notes: Output shows the inverse of its last bit when deselected
`timescale 1ns/10ps
module ee_model #(
  parameter int AB = 6
) (
  // Memory pins
  input wire logic cs,
  input wire logic sk,
  input wire logic di,
  output logic dq
);
  logic [15:0] mem [64];
  logic [9:0] a = '0;
  int n = 0;
  initial dq = 1'b1;
  // New frame restarts the bit count
  always @(posedge cs) begin
    n = 0;
    a = '0;
  end
  // Op and address bits taken on rising clock, MSB first
  always @(posedge sk) if (cs) begin
    n = n + 1;
    if (n > 3 && n <= 3 + AB) a = {a[8:0], di};
  end
  // Dummy zero, then the word MSB first after each falling clock
  always @(negedge sk) if (cs && n >= 3 + AB && n <= 19 + AB) begin
    dq <= (n == 3 + AB) ? 1'b0 : mem[a[5:0]][19 + AB - n];
  end
  // Released line must not keep showing the last bit
  always @(negedge cs) dq <= ~dq;
endmodule // ee_model

// ==== serial_register_access_port_tb.sv ====
// Purpose: Self-checking bench of the serial register access port
// Assumes: Link clock 800 ns, device id 0, size strap 00
// Notes: Register space and serial master are modelled here
`timescale 1ns/10ps
module serial_register_access_port_tb
  import sra_pkg::*;
;
  logic clk = 0, resetn = 0, strap = 0, sck = 0, ssn = 1, mosi = 0;
  logic ack = 0;
  logic [63:0] rdata = 64'h8877665544332211;
  logic [7:0] txb [10], rxb [10];
  logic [79:0] expq [$];
  logic [31:0] rs = 32'd23041;
  int mismatches = 0, checks_done = 0, dly = 0;
  wire ck_o, ck_oe, sl_o, sl_oe, mo_o, mo_oe, mi_o, mi_oe, ee_do;
  wire rq, wr, pres, done, fast;
  wire [7:0] pg, ad;
  wire [63:0] wd;
  wire [3:0] wid = (ad[7:4] == 4'h2) ? 4'h8 : 4'h2;

  serial_register_access_port u_serial_register_access_port (
    .clk(clk), .resetn(resetn), .loader_strap(strap),
    .rom_size_select(2'h0), .init_done(1'b1),
    .receive_ready_flag(1'b1), .transmit_ready_flag(1'b0),
    .ser_clk_i(ck_oe ? ck_o : sck), .ser_clk_o(ck_o), .ser_clk_oe(ck_oe),
    .ser_sel_i(sl_oe ? sl_o : ssn), .ser_sel_o(sl_o), .ser_sel_oe(sl_oe),
    .ser_mosi_i(mo_oe ? mo_o : mosi), .ser_mosi_o(mo_o),
    .ser_mosi_oe(mo_oe), .ser_miso_i(mi_oe ? mi_o : ee_do),
    .ser_miso_o(mi_o), .ser_miso_oe(mi_oe),
    .reg_req(rq), .reg_write(wr), .reg_page(pg), .reg_addr(ad),
    .reg_wdata(wd), .reg_ack(ack), .reg_rdata(rdata), .reg_width(wid),
    .loader_present(pres), .loader_done(done), .loader_fast(fast));
  ee_model u_ee_model (.cs(sl_oe & sl_o), .sk(ck_o), .di(mo_o),
    .dq(ee_do));

  initial forever #50 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction

  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    checks_done++;
    if (a !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, a, e);
    end
  endtask

  // One frame of n bytes, mode 0, MSB first, 800 ns link clock
  task automatic fr(input int n, input logic [63:0] v);
    for (int b = 0; b < 8; b++) txb[b] = v[63 - 8*b -: 8];
    @(posedge clk) ssn <= 1'b0;
    for (int b = 0; b < n; b++)
      for (int i = 7; i >= 0; i--) begin
        mosi <= txb[b][i];
        repeat (4) @(posedge clk);
        sck <= 1'b1;
        rxb[b][i] = mi_o;
        repeat (4) @(posedge clk);
        sck <= 1'b0;
      end
    repeat (4) @(posedge clk);
    ssn <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  task automatic print_verdict();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Register space: acks a held request after a random short wait
  always @(posedge clk) begin
    ack <= 1'b0;
    if (rq && !ack) begin
      if (dly == 0) begin
        ack <= 1'b1;
        rs = xs(rs);
        dly = rs[1:0];
      end else begin
        dly--;
      end
    end
  end

  // Each register write is compared with the oldest noted one
  always @(posedge clk) if (rq && ack && wr) begin
    checks_done++;
    if (expq.size() == 0 || expq[0] !== {pg, ad, wd}) begin
      mismatches++;
      $display("[FAIL] %0t write %h %h %h", $time, pg, ad, wd);
    end
    if (expq.size() != 0) void'(expq.pop_front());
  end

  initial begin
    logic [15:0] v;
    int k;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    expq.push_back({8'h00, 8'h10, 64'h1234});
    fr(4, {8'h61, 8'h10, 8'h34, 8'h12, 32'h0});
    fr(3, {8'h61, 8'h10, 8'h56, 40'h0});
    fr(4, {8'h63, 8'h10, 8'h56, 8'h78, 32'h0});
    fr(3, {8'h61, 8'hff, 8'h05, 40'h0});
    fr(3, {8'h60, 8'hff, 48'h0});
    chk(rxb[2], 8'h05);
    rs = xs(rs);
    v = rs[15:0];
    expq.push_back({8'h05, 8'h10, 48'h0, v});
    fr(4, {8'h71, 8'h10, v[7:0], v[15:8], 32'h0});
    fr(2, {8'h60, 8'h20, 48'h0});
    k = 0;
    do begin
      fr(3, {8'h60, 8'hfe, 48'h0});
      k++;
    end while (rxb[2][5] !== 1'b1 && k < 20);
    chk(rxb[2], 8'h22);
    fr(5, {8'h60, 8'hf2, 48'h0});
    for (int i = 2; i < 5; i++) chk(rxb[i], rdata[8*i+7 -: 8]);
    fr(3, {8'h60, 8'hf0, 48'h0});
    chk(rxb[2], 8'h11);
    fr(8, {8'h70, 8'h20, 48'h0});
    k = 2;
    while (k < 7 && rxb[k] !== 8'h01) k++;
    chk(rxb[k + 1], 8'h44);
    // Loader run: header of two entries, one register write
    u_ee_model.mem[0] = {8'h02, HDR_MAGIC, 1'b1, 2'h0};
    u_ee_model.mem[1] = 16'h1003;
    u_ee_model.mem[2] = 16'h3412;
    expq.push_back({8'h03, 8'h10, 64'h1234});
    resetn <= 1'b0;
    strap <= 1'b1;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    k = 0;
    while (done !== 1'b1 && k < 5000) begin
      @(posedge clk);
      k++;
    end
    chk({5'h0, pres, done, fast}, 8'h07);
    chk(8'(expq.size()), 8'h00);
    // Header without the magic code: loader stops, nothing is written
    u_ee_model.mem[0] = 16'h0000;
    resetn <= 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (400) @(posedge clk);
    chk({5'h0, pres, done, fast}, 8'h00);
    print_verdict();
  end
endmodule // serial_register_access_port_tb
